// *** src/hpf_pkg.sv ***
/*
 pin-function select package: constants and carriers for the host port
 pin group (five shared pins). assumes one 250 MHz clock domain.
*/
`default_nettype none
package hpf_pkg;
	localparam int HPF_NPINS = 5;
	// pin indices within the group (port bits 10..14)
	localparam int PIN_ADDR = 0;
	localparam int PIN_RW = 1;
	localparam int PIN_DS = 2;
	localparam int PIN_CS = 3;
	localparam int PIN_REQ = 4;
	// per-pin gpio direction encoding
	localparam logic [1:0] GP_DISC = 2'h0;
	localparam logic [1:0] GP_IN = 2'h1;
	localparam logic [1:0] GP_OUT = 2'h2;
	// reset values: polarity 0 means active low
	localparam logic RST_POL = 1'h0;
	localparam logic RST_FUNC = 1'h0;
	localparam logic [9:0] RST_GP_DIR = 10'h000;
	localparam int SYNC_STAGES = 3;

	typedef struct packed {
		logic host_fn;
		logic muxed_bus;
		logic double_strobe;
		logic double_req;
		logic req_open_drain;
		logic pol_rd;
		logic pol_ds;
		logic pol_cs;
		logic pol_req;
	} hpf_cfg_t;

	typedef struct packed {
		logic host_addr_in_line_two;
		logic host_addr_in_line_nine;
		logic host_addr_in_line_ten;
		logic host_read_write_dir;
		logic host_read_strobe;
		logic host_single_strobe;
		logic host_write_strobe;
		logic host_select_in;
	} hpf_host_in_t;
endpackage
`default_nettype wire

// *** src/hpf_sync.sv ***
/*
 three-flop input synchroniser with agree filter.
 assumes async input, one clock; output changes once stages 2 and 3 agree.
*/
`default_nettype none
module hpf_sync
	import hpf_pkg::*;
#(
	parameter int WIDTH = HPF_NPINS
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// data
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	initial
	begin
		if (WIDTH < 1)
			$error("hpf_sync: WIDTH must be positive");
	end

	logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
	logic [WIDTH-1:0] out_next;

	always_comb
	begin
		out_next = out_reg;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (s2_reg[i] == s3_reg[i])
				out_next[i] = s3_reg[i];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			out_reg <= '0;
		end
		else
		begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			out_reg <= out_next;
		end
	end

	assign dout = out_reg;
endmodule
`default_nettype wire

// *** src/hpf_pin_select.sv ***
/*
 host port pin-function select for the five shared pins that carry
 address lines 2/9, read-write or read strobe, data or write strobe,
 chip select or address 10, and the host request output.
 assumes: configuration comes from same-clock logic; pins are async.
*/
`default_nettype none
// Function
// [R1] non-muxed host: pin0 is address line two
// [R2] muxed host: pin0 is address line nine
// [R3] muxed host: select pin is address ten
// [R4] single strobe: pin1 is read-write direction
// [R5] double strobe: pin1 read strobe, programmable polarity
// [R6] single strobe: pin2 data strobe, programmable polarity
// [R7] double strobe: pin2 write strobe, programmable polarity
// [R8] non-muxed: pin3 chip select, programmable polarity
// [R9] single request: pin4 host request, polarity
// [R10] double request: pin4 transmit request, polarity
// [R11] request output driven or open-drain
// [R12] gpio mode: each bit in/out/disconnected
// [R13] reset: all pins gpio disconnected
// [R14] inputs synchronised and made active high
module hpf_pin_select
	import hpf_pkg::*;
#(
	parameter int NPINS = HPF_NPINS
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// configuration from same-clock logic
	input wire hpf_cfg_t cfg,
	input wire logic [2*NPINS-1:0] gp_dir,
	input wire logic [NPINS-1:0] gp_out_val,
	// request from the port's handshake logic, active high
	input wire logic req_int,
	// pins: input, output, output enable
	input wire logic [NPINS-1:0] pin_in,
	output logic [NPINS-1:0] pin_out,
	output logic [NPINS-1:0] pin_oe,
	// decoded host-side signals, active high
	output hpf_host_in_t host_in,
	output logic host_request_out,
	output logic host_transmit_request_out,
	// gpio read back (port bits 10..14)
	output logic [NPINS-1:0] gp_in_val
);
	initial
	begin
		if (NPINS != HPF_NPINS)
			$error("hpf_pin_select: NPINS must equal the pin group size");
	end

	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic rst_s1_reg, rst_s2_reg;
	logic rst_n;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_s1_reg <= 1'h0;
			rst_s2_reg <= 1'h0;
		end
		else
		begin
			rst_s1_reg <= 1'h1;
			rst_s2_reg <= rst_s1_reg;
		end
	end

	assign rst_n = rst_s2_reg;

	// ---------------------------------------------------------------
	// pin input synchronisation
	// ---------------------------------------------------------------
	logic [NPINS-1:0] pin_sync;

	hpf_sync #(
		.WIDTH(NPINS)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din(pin_in),
		.dout(pin_sync)
	); // [R14]

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// polarity fix: pol 0 means the pin is active low
	function automatic logic to_active_high(input logic lvl, input logic pol);
		to_active_high = pol ? lvl : ~lvl;
	endfunction

	function automatic logic [1:0] dir_of(input logic [2*NPINS-1:0] d, input int idx);
		dir_of = d[2*idx +: 2];
	endfunction

	// ---------------------------------------------------------------
	// input decode
	// ---------------------------------------------------------------
	hpf_host_in_t host_in_reg, host_in_next;
	logic [NPINS-1:0] gp_in_reg, gp_in_next;

	always_comb
	begin
		host_in_next = '0;
		gp_in_next = '0;
		if (cfg.host_fn)
		begin
			if (cfg.muxed_bus)
			begin
				host_in_next.host_addr_in_line_nine = pin_sync[PIN_ADDR]; // [R2]
				host_in_next.host_addr_in_line_ten = pin_sync[PIN_CS]; // [R3]
			end
			else
			begin
				host_in_next.host_addr_in_line_two = pin_sync[PIN_ADDR]; // [R1]
				host_in_next.host_select_in = to_active_high(pin_sync[PIN_CS], cfg.pol_cs); // [R8] [R14]
			end
			if (cfg.double_strobe)
			begin
				host_in_next.host_read_strobe = to_active_high(pin_sync[PIN_RW], cfg.pol_rd); // [R5] [R14]
				host_in_next.host_write_strobe = to_active_high(pin_sync[PIN_DS], cfg.pol_ds); // [R7] [R14]
			end
			else
			begin
				host_in_next.host_read_write_dir = pin_sync[PIN_RW]; // [R4]
				host_in_next.host_single_strobe = to_active_high(pin_sync[PIN_DS], cfg.pol_ds); // [R6] [R14]
			end
		end
		else
		begin
			// disconnected or output bits read as zero, not the pin
			for (int i = 0; i < NPINS; i++)
			begin
				if (dir_of(gp_dir, i) == GP_IN)
					gp_in_next[i] = pin_sync[i]; // [R12]
			end
		end
	end

	// ---------------------------------------------------------------
	// output drive
	// ---------------------------------------------------------------
	logic [NPINS-1:0] pin_out_reg, pin_out_next;
	logic [NPINS-1:0] pin_oe_reg, pin_oe_next;
	logic req_reg, req_next;
	logic treq_reg, treq_next;
	logic req_level;

	always_comb
	begin
		pin_out_next = '0;
		pin_oe_next = '0;
		req_next = 1'h0;
		treq_next = 1'h0;
		req_level = req_int ^ ~cfg.pol_req; // [R9] [R10]
		if (cfg.host_fn)
		begin
			if (cfg.double_req)
				treq_next = req_int; // [R10]
			else
				req_next = req_int; // [R9]
			pin_out_next[PIN_REQ] = req_level;
			// open drain only drives while asserted, otherwise floats
			if (cfg.req_open_drain)
				pin_oe_next[PIN_REQ] = req_int; // [R11]
			else
				pin_oe_next[PIN_REQ] = 1'h1; // [R11]
		end
		else
		begin
			for (int i = 0; i < NPINS; i++)
			begin
				if (dir_of(gp_dir, i) == GP_OUT)
				begin
					pin_out_next[i] = gp_out_val[i]; // [R12]
					pin_oe_next[i] = 1'h1; // [R12]
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// state registers
	// ---------------------------------------------------------------
	// everything clears to gpio disconnected: no drive, inputs read zero
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			host_in_reg <= '0; // [R13]
			gp_in_reg <= '0; // [R13]
			pin_out_reg <= '0; // [R13]
			pin_oe_reg <= '0; // [R13]
			req_reg <= 1'h0;
			treq_reg <= 1'h0;
		end
		else
		begin
			host_in_reg <= host_in_next;
			gp_in_reg <= gp_in_next;
			pin_out_reg <= pin_out_next;
			pin_oe_reg <= pin_oe_next;
			req_reg <= req_next;
			treq_reg <= treq_next;
		end
	end

	assign host_in = host_in_reg;
	assign gp_in_val = gp_in_reg;
	assign pin_out = pin_out_reg;
	assign pin_oe = pin_oe_reg;
	assign host_request_out = req_reg;
	assign host_transmit_request_out = treq_reg;
endmodule
`default_nettype wire

// *** verif/hpf_pin_select_props.sv ***
/*
 port checker for the pin select, bound to every instance.
 assumes config and request come from the same clock.
*/
`default_nettype none
module hpf_pin_select_props
	import hpf_pkg::*;
#(parameter int NPINS = HPF_NPINS)
(
	// watched ports
	input wire logic clk,
	input wire logic rstn,
	input wire hpf_cfg_t cfg,
	input wire logic [2*NPINS-1:0] gp_dir,
	input wire logic [NPINS-1:0] gp_out_val,
	input wire logic req_int,
	input wire logic [NPINS-1:0] pin_in,
	input wire logic [NPINS-1:0] pin_out,
	input wire logic [NPINS-1:0] pin_oe,
	input wire hpf_host_in_t host_in,
	input wire logic host_request_out,
	input wire logic host_transmit_request_out,
	input wire logic [NPINS-1:0] gp_in_val
);
	logic [1:0] up;
	hpf_cfg_t pc;
	logic [NPINS-1:0] oe_exp;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	always_comb
		for (int i = 0; i < NPINS; i++)
			oe_exp[i] = gp_dir[2*i+:2] == GP_OUT;
	// outputs only follow config once the reset copy has let go
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			up <= 2'h0;
		else if (up != 2'h3)
			up <= up + 2'h1;
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			pc <= 9'h000;
		else
			pc <= cfg;
	chk_reset_quiet: assert property (up != 2'h3 |-> pin_oe == '0 && gp_in_val == '0)
		else $error("pin active early");
	chk_gpio_drive: assert property (up == 2'h3 && !pc.host_fn |-> pin_oe == $past(oe_exp)
		&& (pin_out & pin_oe) == ($past(gp_out_val) & pin_oe)) else $error("gpio drive wrong");
	chk_host_inputs: assert property (up == 2'h3 && pc.host_fn |-> pin_oe[PIN_CS:0] == '0)
		else $error("host input driven");
	chk_req_driven: assert property (up == 2'h3 && pc.host_fn && !pc.req_open_drain
		|-> pin_oe[PIN_REQ] && pin_out[PIN_REQ] == ($past(req_int) ~^ pc.pol_req)) else $error("request wrong");
	chk_req_odrain: assert property (up == 2'h3 && pc.host_fn && pc.req_open_drain
		|-> pin_oe[PIN_REQ] == $past(req_int) && (!pin_oe[PIN_REQ] || pin_out[PIN_REQ] == pc.pol_req))
		else $error("open drain wrong");
	chk_req_single: assert property (up == 2'h3 && pc.host_fn
		|-> host_request_out == ($past(req_int) && !pc.double_req)) else $error("single request wrong");
	chk_req_double: assert property (up == 2'h3 && pc.host_fn
		|-> host_transmit_request_out == ($past(req_int) && pc.double_req)) else $error("double request wrong");
	chk_req_gpio: assert property (up == 2'h3 && !pc.host_fn
		|-> !host_request_out && !host_transmit_request_out) else $error("request in gpio mode");
endmodule
bind hpf_pin_select hpf_pin_select_props #(.NPINS(NPINS)) u_props (.clk, .rstn, .cfg, .gp_dir, .gp_out_val,
	.req_int, .pin_in, .pin_out, .pin_oe, .host_in, .host_request_out, .host_transmit_request_out, .gp_in_val);
`default_nettype wire

// *** verif/hpf_host_model.sv ***
/*
 host side of the five shared pins.
 assumes a pull-up on every pin; the host drives where host_oe is set.
*/
`default_nettype none
module hpf_host_model
	import hpf_pkg::*;
(
	// device side
	input wire logic [HPF_NPINS-1:0] pin_oe,
	input wire logic [HPF_NPINS-1:0] pin_out,
	// host side
	input wire logic [HPF_NPINS-1:0] host_oe,
	input wire logic [HPF_NPINS-1:0] host_val,
	// wire level
	output logic [HPF_NPINS-1:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// a released line rests high, so an idle open-drain request reads high
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~host_oe) | (~pin_oe & host_oe & host_val);
endmodule
`default_nettype wire

// *** verif/hpf_pin_select_tb.sv ***
/*
 bench for the pin select: gpio, host decode and request modes.
 assumes the host model resolves each pin level.
*/
`default_nettype none
module hpf_pin_select_tb
	import hpf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic req_int = 1'h0;
	hpf_cfg_t cfg = 9'h000;
	logic [9:0] gp_dir = 10'h000;
	logic [4:0] gp_out_val = 5'h00, ho = 5'h00, hv = 5'h00;
	logic [4:0] pin_in, pin_out, pin_oe, gp_in_val;
	hpf_host_in_t host_in;
	logic host_request_out, host_transmit_request_out;
	int error_cnt = 0;
	int checks = 0;
	int cyc = 0;
	always #2 clk = ~clk;
	hpf_pin_select u_dut (.clk, .rstn, .cfg, .gp_dir, .gp_out_val, .req_int, .pin_in, .pin_out, .pin_oe,
		.host_in, .host_request_out, .host_transmit_request_out, .gp_in_val);
	hpf_host_model u_host (.pin_oe, .pin_out, .host_oe(ho), .host_val(hv), .pin_in);
	task automatic chk(input string n, input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	// the pin path takes five edges, so eight cycles always settle
	task automatic drv(input logic [8:0] c, input logic [9:0] d, input logic [4:0] v, r, e, h);
		@(negedge clk);
		{cfg, gp_dir, gp_out_val, req_int, ho, hv} = {c, d, v, r[0], e, h};
		repeat (8) @(negedge clk);
	endtask
	task automatic results;
		if (error_cnt == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk)
		if (cyc++ > 500)
		begin
			error_cnt++;
			results();
		end
	initial
	begin
		repeat (8) @(negedge clk);
		rstn = 1'h1;
		@(negedge clk);
		chk("reset", {host_in, 3'h0, pin_oe | gp_in_val}, 16'h0000);
		drv(9'h000, 10'h1c6, 5'h01, 5'h00, 5'h1e, 5'h1e);
		chk("gpio mix", {1'h0, pin_oe, pin_in, gp_in_val}, 16'h07f2);
		drv(9'h000, 10'h2aa, 5'h15, 5'h00, 5'h00, 5'h00);
		chk("gpio out", {1'h0, pin_oe, pin_in, gp_in_val}, 16'h7ea0);
		drv(9'h100, 10'h2aa, 5'h15, 5'h01, 5'h0f, 5'h03);
		chk("host plain", {host_in, pin_in[4], host_request_out, host_transmit_request_out, pin_oe}, 16'h9550);
		drv(9'h1cc, 10'h2aa, 5'h15, 5'h00, 5'h0f, 5'h0b);
		chk("host muxed", {host_in, pin_in[4], host_request_out, host_transmit_request_out, pin_oe}, 16'h6890);
		drv(9'h131, 10'h000, 5'h00, 5'h00, 5'h0f, 5'h0b);
		chk("od idle", {host_in, pin_in[4], host_request_out, host_transmit_request_out, pin_oe}, 16'h9480);
		drv(9'h131, 10'h000, 5'h00, 5'h01, 5'h0f, 5'h0b);
		chk("od active", {host_in, pin_in[4], host_request_out, host_transmit_request_out, pin_oe}, 16'h94b0);
		results();
	end
endmodule
`default_nettype wire
